// ---- spi_pkg.sv ----
// shared constants and types for the protected-register serial link
package spi_pkg;

    // frame layout, most significant bit first
    localparam int         FRAME_BITS   = 16;
    localparam logic [4:0] FRAME_LEN    = 5'h10;
    localparam logic [4:0] CNT_SAT      = 5'h11;
    localparam logic [4:0] CNT_ADDR_END = 5'h06;
    localparam logic [4:0] CNT_PAR_SLOT = 5'h0e;
    localparam logic       CMD_READ     = 1'b0;
    localparam logic       CMD_WRITE    = 1'b1;
    localparam logic       REPLY_CMD    = 1'b1;

    // device register addresses
    localparam logic [5:0] ADDR_KEY     = 6'h01;
    localparam logic [5:0] ADDR_FLAGS   = 6'h02;
    localparam logic [5:0] ADDR_PROT    = 6'h03;
    localparam logic [5:0] ADDR_WD_REQ  = 6'h10;
    localparam logic [5:0] ADDR_WD_ACT  = 6'h11;
    localparam logic [7:0] WD_REQ_RST   = 8'h00;

    // error flag positions
    localparam int         FLAGS_W      = 5;
    localparam int         FLG_PAR      = 0;
    localparam int         FLG_ADDR     = 1;
    localparam int         FLG_LEN      = 2;
    localparam int         FLG_DUR      = 3;
    localparam int         FLG_SEQ      = 4;

    // key sequences, entry 0 is written first
    localparam logic [3:0][7:0] UNLOCK_KEYS = {8'h12, 8'h56, 8'hef, 8'hab};
    localparam logic [3:0][7:0] LOCK_KEYS   = {8'hca, 8'hbe, 8'h34, 8'hdf};
    localparam logic [1:0]      KEY_LAST    = 2'h3;

    // timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          MAX_FRAME_NS    = 10000;
    localparam logic [10:0] MAX_FRAME_CYC   = 11'(MAX_FRAME_NS / CLK_PERIOD_NS);
    localparam int          CFG_APPLY_US    = 60;
    localparam logic [7:0]  SCL_HALF_CYC    = 8'h08;
    localparam logic [3:0]  HOST_LAST_BIT   = 4'hf;

    // host register offsets and fields
    localparam logic [7:0] WB_CTRL      = 8'h00;
    localparam logic [7:0] WB_STAT      = 8'h04;
    localparam logic [7:0] WB_RX        = 8'h08;
    localparam int         CTRL_BAD_PAR = 16;

    typedef enum logic [2:0] {
        DS_IDLE  = 3'b001,
        DS_SHIFT = 3'b010,
        DS_ABORT = 3'b100
    } dev_state_t;

    typedef enum logic [5:0] {
        HS_IDLE  = 6'b000001,
        HS_LEAD  = 6'b000010,
        HS_HIGH  = 6'b000100,
        HS_LOW   = 6'b001000,
        HS_TRAIL = 6'b010000,
        HS_GAP   = 6'b100000
    } host_state_t;

endpackage : spi_pkg

// ---- spi_link_if.sv ----
// serial link between the controller and the protected-register device
`timescale 1ns/1ps
interface spi_link_if;
    logic chip_select_pin_n;
    logic scl;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic irq;
    logic sdo_line;

    // released data line reads low
    assign sdo_line = sdo_oe_n ? 1'b0 : sdo;

    modport dev  (input chip_select_pin_n, input scl, input sdi, output sdo, output sdo_oe_n, output irq);
    modport host (output chip_select_pin_n, output scl, output sdi, input sdo_line, input irq);
endinterface : spi_link_if

// ---- pin_sync.sv ----
// two-stage synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // asynchronous inputs and their synchronised forms
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q,
    output logic      [W-1:0] q_d
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_ff;
        logic sync_ff;
        logic dly_ff;
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                meta_ff <= 1'b0;
                sync_ff <= 1'b0;
                dly_ff  <= 1'b0;
            end else begin
                meta_ff <= din[i];
                sync_ff <= meta_ff;
                dly_ff  <= sync_ff;
            end
        end
        assign q[i]   = sync_ff;
        assign q_d[i] = dly_ff;
    end
endmodule : pin_sync

// ---- spi_dev_end.sv ----
// device end: serial slave with frame checks and key-protected configuration
// Operation
// - sample input on fall, shift on rise
// - output changes on fall, master captures fall
// - master sends command, address, data, parity
// - read reply: command, status, data, parity
// - write frames echo input bits on output
// - zero reads, one writes; reply command one
// - parity is XOR of fifteen bits
// - receiver checks parity before using payload
// - parity mismatch: discard, flag, interrupt
// - write to bad address: discard, flag
// - read bad address: zeros, wrong parity, flag
// - write wrong length: discard, length flag
// - read wrong length: still drive, flag
// - overlong frame: release output, duration flag
// - interrupt only after frame end or timeout
// - protected pairs, locked after reset, readable
// - new configuration applied within sixty microseconds
// - protected reads always allowed, request register returns inverted
// - master rewrites or verifies all before locking
// - unlock keys written consecutively, progress bits
// - lock keys disable writes, copy to active
// - wrong key or other write: reset, flag
// - pending errors drive interrupt output
`timescale 1ns/1ps
module spi_dev_end (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         nrst,
    // link toward the master
    spi_link_if.dev                           link,
    // user side
    output logic      [spi_pkg::FLAGS_W-1:0]  spi_error_flags,
    output logic                              protection_state_bit,
    output logic      [7:0]                   watchdog_config_active
);
    import spi_pkg::*;

    logic [2:0]         pin_q;
    logic [2:0]         pin_d;
    logic               cs_fall;
    logic               cs_rise;
    logic               scl_fall;
    logic               scl_rise;
    logic               sdi_s;
    dev_state_t         state_ff;
    dev_state_t         nxt_state;
    logic [4:0]         bit_cnt_ff;
    logic [10:0]        tmr_ff;
    logic               samp_ff;
    logic [14:0]        rx_ff;
    logic               cmd_ff;
    logic [7:0]         tx_ff;
    logic               par_ff;
    logic               bad_rd_ff;
    logic               sdo_ff;
    logic               sdo_oe_n_ff;
    logic [FLAGS_W-1:0] flags_ff;
    logic [3:0]         progress_ff;
    logic [3:0]         nxt_progress;
    logic               seq_lock_ff;
    logic               nxt_seq_lock;
    logic               prot_ff;
    logic [7:0]         wd_req_ff;
    logic [7:0]         wd_act_ff;
    logic               irq_ff;
    logic               frame_end;
    logic               timeout;
    logic [15:0]        frame_w;
    logic [5:0]         f_addr;
    logic [7:0]         f_data;
    logic               len_ok;
    logic               par_ok;
    logic               ev_len;
    logic               ev_par;
    logic               ev_addr;
    logic               wr_ok;
    logic               key_wr;
    logic               other_wr;
    logic [1:0]         key_idx;
    logic [7:0]         key_exp;
    logic               seq_err;
    logic               seq_done;
    logic [5:0]         rd_addr;
    logic [7:0]         rd_data;
    logic               wr_frame;
    logic [FLAGS_W-1:0] flag_set;
    logic [FLAGS_W-1:0] flag_clr;

    function automatic logic addr_ok(input logic [5:0] a);
        case (a)
            ADDR_KEY, ADDR_FLAGS, ADDR_PROT, ADDR_WD_REQ, ADDR_WD_ACT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    pin_sync #(.W(3)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      ({link.chip_select_pin_n, link.scl, link.sdi}),
        .q        (pin_q),
        .q_d      (pin_d)
    );

    assign cs_fall  = pin_d[2] & ~pin_q[2];
    assign cs_rise  = ~pin_d[2] & pin_q[2];
    assign scl_fall = pin_d[1] & ~pin_q[1];
    assign scl_rise = ~pin_d[1] & pin_q[1];
    assign sdi_s    = pin_q[0];

    assign frame_end = (state_ff == DS_SHIFT) && cs_rise;
    assign timeout   = (state_ff == DS_SHIFT) && !cs_rise && (tmr_ff == MAX_FRAME_CYC);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DS_IDLE:  if (cs_fall) nxt_state = DS_SHIFT;
            DS_SHIFT: if (cs_rise) nxt_state = DS_IDLE; else if (timeout) nxt_state = DS_ABORT;
            DS_ABORT: if (cs_rise) nxt_state = DS_IDLE;
            default:  nxt_state = DS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) state_ff <= DS_IDLE;
        else       state_ff <= nxt_state;
    end

    // falling-edge count and frame timer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bit_cnt_ff <= 5'h00;
            tmr_ff     <= 11'h000;
        end else if (state_ff == DS_IDLE) begin
            bit_cnt_ff <= 5'h00;
            tmr_ff     <= 11'h000;
        end else if (state_ff == DS_SHIFT) begin
            tmr_ff <= tmr_ff + 11'h001;
            if (scl_fall && bit_cnt_ff != CNT_SAT) bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // receive path
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            samp_ff <= 1'b0;
            rx_ff   <= 15'h0000;
            cmd_ff  <= CMD_READ;
        end else if (state_ff == DS_SHIFT) begin
            if (scl_fall) samp_ff <= sdi_s;
            if (scl_fall && bit_cnt_ff == 5'h00) cmd_ff <= sdi_s;
            if (scl_rise) rx_ff <= {rx_ff[13:0], samp_ff};
        end
    end

    // read data chosen once the address is complete
    assign rd_addr  = {rx_ff[4:0], sdi_s};
    assign wr_frame = ((bit_cnt_ff == 5'h00) ? sdi_s : cmd_ff) == CMD_WRITE;
    always_comb begin
        case (rd_addr)
            ADDR_KEY:    rd_data = {4'h0, progress_ff};
            ADDR_FLAGS:  rd_data = {3'h0, flags_ff};
            ADDR_PROT:   rd_data = {7'h00, prot_ff};
            ADDR_WD_REQ: rd_data = ~wd_req_ff;
            ADDR_WD_ACT: rd_data = wd_act_ff;
            default:     rd_data = 8'h00;
        endcase
    end

    // transmit path, one bit ahead of each falling edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sdo_ff      <= 1'b0;
            sdo_oe_n_ff <= 1'b1;
            tx_ff       <= 8'h00;
            par_ff      <= 1'b0;
            bad_rd_ff   <= 1'b0;
        end else if (state_ff == DS_IDLE && cs_fall) begin
            sdo_ff      <= REPLY_CMD;
            par_ff      <= REPLY_CMD;
            tx_ff       <= {flags_ff, prot_ff, 2'h0};
            sdo_oe_n_ff <= 1'b0;
            bad_rd_ff   <= 1'b0;
        end else if (state_ff == DS_SHIFT) begin
            if (cs_rise || timeout) begin
                sdo_oe_n_ff <= 1'b1;
            end else if (scl_fall && bit_cnt_ff < 5'h0f) begin
                if (wr_frame) begin
                    sdo_ff <= sdi_s;
                end else if (bit_cnt_ff == CNT_PAR_SLOT) begin
                    sdo_ff <= par_ff ^ bad_rd_ff;
                end else if (bit_cnt_ff == CNT_ADDR_END) begin
                    sdo_ff    <= rd_data[7];
                    par_ff    <= par_ff ^ rd_data[7];
                    tx_ff     <= {rd_data[6:0], 1'b0};
                    bad_rd_ff <= ~addr_ok(rd_addr);
                end else begin
                    sdo_ff <= tx_ff[7];
                    par_ff <= par_ff ^ tx_ff[7];
                    tx_ff  <= {tx_ff[6:0], 1'b0};
                end
            end
        end
    end

    // frame checks at chip-select release
    assign frame_w  = {rx_ff, samp_ff};
    assign f_addr   = frame_w[14:9];
    assign f_data   = frame_w[8:1];
    assign len_ok   = bit_cnt_ff == FRAME_LEN;
    assign par_ok   = ~^frame_w;
    assign ev_len   = frame_end && !len_ok;
    assign ev_par   = frame_end && len_ok && !par_ok;
    assign ev_addr  = frame_end && len_ok && par_ok && !addr_ok(f_addr);
    assign wr_ok    = frame_end && len_ok && par_ok && addr_ok(f_addr) && frame_w[15] == CMD_WRITE;
    assign key_wr   = wr_ok && f_addr == ADDR_KEY;
    assign other_wr = wr_ok && f_addr != ADDR_KEY;

    assign key_idx = progress_ff[2] ? 2'h3 : progress_ff[1] ? 2'h2 : progress_ff[0] ? 2'h1 : 2'h0;
    assign key_exp = seq_lock_ff ? LOCK_KEYS[key_idx] : UNLOCK_KEYS[key_idx];

    always_comb begin
        nxt_progress = progress_ff;
        nxt_seq_lock = seq_lock_ff;
        seq_err      = 1'b0;
        seq_done     = 1'b0;
        if (key_wr) begin
            if (progress_ff == 4'h0) begin
                if (f_data == UNLOCK_KEYS[0]) begin
                    nxt_progress = 4'h1;
                    nxt_seq_lock = 1'b0;
                end else if (f_data == LOCK_KEYS[0]) begin
                    nxt_progress = 4'h1;
                    nxt_seq_lock = 1'b1;
                end else begin
                    seq_err = 1'b1;
                end
            end else if (f_data == key_exp) begin
                if (key_idx == KEY_LAST) begin
                    nxt_progress = 4'h0;
                    seq_done     = 1'b1;
                end else begin
                    nxt_progress = {progress_ff[2:0], 1'b1};
                end
            end else begin
                nxt_progress = 4'h0;
                seq_err      = 1'b1;
            end
        end else if (other_wr && progress_ff != 4'h0) begin
            nxt_progress = 4'h0;
            seq_err      = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            progress_ff <= 4'h0;
            seq_lock_ff <= 1'b0;
        end else begin
            progress_ff <= nxt_progress;
            seq_lock_ff <= nxt_seq_lock;
        end
    end

    // protection state and configuration pair
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prot_ff   <= 1'b1;
            wd_act_ff <= WD_REQ_RST;
        end else if (seq_done) begin
            prot_ff <= seq_lock_ff;
            if (seq_lock_ff) wd_act_ff <= wd_req_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst)                                       wd_req_ff <= WD_REQ_RST;
        else if (wr_ok && f_addr == ADDR_WD_REQ && !prot_ff) wd_req_ff <= f_data;
    end

    // sticky flags, write one to clear, a new event wins over its clear
    always_comb begin
        flag_set           = '0;
        flag_set[FLG_PAR]  = ev_par;
        flag_set[FLG_ADDR] = ev_addr;
        flag_set[FLG_LEN]  = ev_len;
        flag_set[FLG_DUR]  = timeout;
        flag_set[FLG_SEQ]  = seq_err;
        flag_clr           = (wr_ok && f_addr == ADDR_FLAGS) ? f_data[FLAGS_W-1:0] : '0;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) flags_ff <= '0;
        else       flags_ff <= (flags_ff & ~flag_clr) | flag_set;
    end

    // flags change only at frame end or timeout, so mid-frame the line moves only after a timeout has released the output
    always_ff @(posedge core_clk) begin
        if (!nrst) irq_ff <= 1'b0;
        else       irq_ff <= |flags_ff;
    end

    assign link.sdo               = sdo_ff;
    assign link.sdo_oe_n          = sdo_oe_n_ff;
    assign link.irq               = irq_ff;
    assign spi_error_flags        = flags_ff;
    assign protection_state_bit   = prot_ff;
    assign watchdog_config_active = wd_act_ff;
endmodule : spi_dev_end

// ---- spi_host_end.sv ----
// controller end: wishbone slave that runs one serial frame per command
`timescale 1ns/1ps
module spi_host_end (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link toward the device
    spi_link_if.host         link
);
    import spi_pkg::*;

    logic [1:0]  pin_q;
    logic [1:0]  pin_d;
    host_state_t state_ff;
    host_state_t nxt_state;
    logic [7:0]  cnt_ff;
    logic [3:0]  bit_ff;
    logic [15:0] txs_ff;
    logic [15:0] rx_ff;
    logic        scs_n_ff;
    logic        scl_ff;
    logic        sdi_ff;
    logic        busy_ff;
    logic        par_ok_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        acc;
    logic        start;
    logic        half_done;
    logic        rise;
    logic        fall;

    pin_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      ({link.irq, link.sdo_line}),
        .q        (pin_q),
        .q_d      ()
    );

    assign acc       = wb_cyc_i && wb_stb_i && !ack_ff;
    // a write acts at the edge where the master sees ack, while it still holds the request
    assign start     = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_adr_i == WB_CTRL && (&wb_sel_i[1:0])
                       && state_ff == HS_IDLE;
    assign half_done = cnt_ff == SCL_HALF_CYC - 8'h01;
    assign rise      = half_done && (state_ff == HS_LEAD || state_ff == HS_LOW);
    assign fall      = half_done && state_ff == HS_HIGH;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            HS_IDLE:  if (start) nxt_state = HS_LEAD;
            HS_LEAD:  if (half_done) nxt_state = HS_HIGH;
            HS_HIGH:  if (half_done) nxt_state = (bit_ff == HOST_LAST_BIT) ? HS_TRAIL : HS_LOW;
            HS_LOW:   if (half_done) nxt_state = HS_HIGH;
            HS_TRAIL: if (half_done) nxt_state = HS_GAP;
            HS_GAP:   if (half_done) nxt_state = HS_IDLE;
            default:  nxt_state = HS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= HS_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
        end
    end

    // pins: data changes on the rise so it is stable at the device's falling-edge sample
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scs_n_ff <= 1'b1;
            scl_ff   <= 1'b0;
            sdi_ff   <= 1'b0;
            txs_ff   <= 16'h0000;
            bit_ff   <= 4'h0;
        end else if (start) begin
            scs_n_ff <= 1'b0;
            bit_ff   <= 4'h0;
            txs_ff   <= {wb_dat_i[14:0], (^wb_dat_i[14:0]) ^ (wb_sel_i[2] & wb_dat_i[CTRL_BAD_PAR])};
        end else if (rise) begin
            scl_ff <= 1'b1;
            sdi_ff <= txs_ff[15];
            txs_ff <= {txs_ff[14:0], 1'b0};
        end else if (fall) begin
            scl_ff <= 1'b0;
            bit_ff <= bit_ff + 4'h1;
        end else if (half_done && state_ff == HS_TRAIL) begin
            scs_n_ff <= 1'b1;
        end
    end

    // reply captured at each falling edge, checked once the frame is over
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_ff     <= 16'h0000;
            par_ok_ff <= 1'b0;
            busy_ff   <= 1'b0;
        end else begin
            if (fall) rx_ff <= {rx_ff[14:0], pin_q[0]};
            if (start) busy_ff <= 1'b1;
            else if (half_done && state_ff == HS_GAP) begin
                busy_ff   <= 1'b0;
                par_ok_ff <= ~^rx_ff;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= acc;
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    WB_STAT: dat_ff <= {29'h00000000, pin_q[1], par_ok_ff, busy_ff};
                    WB_RX:   dat_ff <= {16'h0000, rx_ff};
                    default: dat_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_o               = ack_ff;
    assign wb_dat_o               = dat_ff;
    assign link.chip_select_pin_n = scs_n_ff;
    assign link.scl               = scl_ff;
    assign link.sdi               = sdi_ff;
endmodule : spi_host_end

// ---- spi_link_properties.sv ----
// wire-level checks on the serial link between the two ends
`timescale 1ns/1ps
module spi_link_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link signals
    input wire logic chip_select_pin_n,
    input wire logic scl,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic irq,
    input wire logic sdo_line
);
    logic [4:0] rises_ff;
    logic       sdi_ff;
    logic       wr_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // clock rises seen inside the current frame
    always_ff @(posedge core_clk) begin
        if (!nrst || chip_select_pin_n) rises_ff <= 5'h00;
        else if ($rose(scl)) rises_ff <= rises_ff + 5'h01;
    end
    always_ff @(posedge core_clk) begin
        if ($fell(scl)) sdi_ff <= sdi;
        if ($fell(scl) && rises_ff == 5'h01) wr_ff <= sdi;
    end
    sequence frame_end;
        $rose(chip_select_pin_n);
    endsequence
    irq_after_frame_a: assert property ($rose(irq) |-> chip_select_pin_n || sdo_oe_n)
        else $error("irq rose inside a frame");
    sdo_stable_a: assert property (scl && $past(scl) && !sdo_oe_n |-> $stable(sdo))
        else $error("sdo moved while clock high");
    write_echo_a: assert property ($fell(scl) && wr_ff && rises_ff > 5'h01 |-> sdo_line == sdi_ff)
        else $error("write echo wrong");
    reply_cmd_a: assert property ($rose(scl) && rises_ff == 5'h00 && !chip_select_pin_n |-> sdo_line)
        else $error("reply command bit not one");
    frame_len_a: assert property (frame_end |-> rises_ff == 5'h10)
        else $error("frame not sixteen clocks");
    release_out_a: assert property (frame_end |-> ##[1:6] sdo_oe_n)
        else $error("sdo not released");
    drive_out_a: assert property ($fell(chip_select_pin_n) |-> ##[1:6] !sdo_oe_n)
        else $error("sdo not driven");
    idle_clock_a: assert property (chip_select_pin_n |-> !scl)
        else $error("clock moved outside frame");
endmodule : spi_link_properties

// ---- spi_slave_protected_regs_tb.sv ----
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/1ps
module spi_slave_protected_regs_tb;
    import spi_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [31:0] wb_wdat  = 32'h0;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic [4:0]  flags;
    logic [4:0]  flags2;
    logic        prot;
    logic [7:0]  act;
    logic [31:0] rd;
    logic        st;
    logic        oe;
    logic        sirq;
    int          err_total = 0;
    int          tests_run = 0;
    spi_link_if lk ();
    spi_link_if lk2 ();
    initial begin
        lk2.chip_select_pin_n = 1'b1;
        lk2.scl = 1'b0;
        lk2.sdi = 1'b1;
    end
    always #5 core_clk = ~core_clk;
    spi_host_end i_spi_host_end (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .link(lk));
    spi_dev_end i_spi_dev_end (.core_clk(core_clk), .nrst(nrst), .link(lk), .spi_error_flags(flags),
        .protection_state_bit(prot), .watchdog_config_active(act));
    spi_dev_end i_spi_dev_end_b (.core_clk(core_clk), .nrst(nrst), .link(lk2), .spi_error_flags(flags2),
        .protection_state_bit(), .watchdog_config_active());
    spi_link_properties i_spi_link_properties (.core_clk(core_clk), .nrst(nrst),
        .chip_select_pin_n(lk.chip_select_pin_n), .scl(lk.scl), .sdi(lk.sdi), .sdo(lk.sdo),
        .sdo_oe_n(lk.sdo_oe_n), .irq(lk.irq), .sdo_line(lk.sdo_line));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, adr, dat, sel};
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus
    // one frame; bad inverts the parity bit
    task automatic frame(input logic bad, input logic cmd, input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, WB_CTRL, 32'({bad, 1'b0, cmd, a, d}), {1'b0, bad, 2'b11});
        do bus(1'b0, WB_STAT, 32'h0, 4'hf); while (rd[0] !== 1'b0);
        st = rd[1];
        sirq = rd[2];
        bus(1'b0, WB_RX, 32'h0, 4'hf);
    endtask : frame
    // raw frame on the second link with n clocks
    task automatic bang(input int n, input int hold);
        lk2.chip_select_pin_n <= 1'b0;
        repeat (hold) @(posedge core_clk);
        repeat (n) begin
            lk2.scl <= 1'b1;
            repeat (8) @(posedge core_clk);
            lk2.scl <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
        oe = lk2.sdo_oe_n;
        lk2.chip_select_pin_n <= 1'b1;
        repeat (12) @(posedge core_clk);
    endtask : bang
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(16'({flags, prot, act}), 16'({5'h00, 1'b1, WD_REQ_RST}));
        frame(1'b0, CMD_WRITE, ADDR_WD_REQ, 8'h5a);
        frame(1'b0, CMD_READ, ADDR_WD_REQ, 8'h00);
        chk(16'({rd[15], rd[8:1], st}), 16'({REPLY_CMD, ~WD_REQ_RST, 1'b1}));
        frame(1'b0, CMD_READ, ADDR_PROT, 8'h00);
        chk(16'(rd[8:1]), 16'h0001);
        for (int i = 0; i < 4; i++) frame(1'b0, CMD_WRITE, ADDR_KEY, UNLOCK_KEYS[i]);
        chk(16'(prot), 16'h0000);
        frame(1'b0, CMD_WRITE, ADDR_WD_REQ, 8'h5a);
        for (int i = 0; i < 4; i++) frame(1'b0, CMD_WRITE, ADDR_KEY, LOCK_KEYS[i]);
        chk(16'({prot, act}), 16'h015a);
        frame(1'b0, CMD_READ, ADDR_WD_REQ, 8'h00);
        chk(16'(rd[8:1]), 16'h00a5);
        frame(1'b0, CMD_WRITE, ADDR_KEY, UNLOCK_KEYS[0]);
        frame(1'b0, CMD_READ, ADDR_KEY, 8'h00);
        chk(16'(rd[4:1]), 16'h0001);
        frame(1'b0, CMD_WRITE, ADDR_KEY, 8'h00);
        frame(1'b0, CMD_READ, ADDR_KEY, 8'h00);
        chk(16'({flags[FLG_SEQ], lk.irq, rd[4:1]}), 16'h0030);
        frame(1'b0, CMD_WRITE, ADDR_FLAGS, 8'h1f);
        frame(1'b0, CMD_READ, 6'h3f, 8'h00);
        chk(16'({rd[8:1], st, flags}), 16'h0002);
        frame(1'b0, CMD_WRITE, ADDR_FLAGS, 8'h1f);
        frame(1'b0, CMD_WRITE, 6'h3f, 8'h00);
        chk(16'(flags), 16'h0002);
        frame(1'b0, CMD_WRITE, ADDR_FLAGS, 8'h1f);
        frame(1'b1, CMD_WRITE, ADDR_FLAGS, 8'h00);
        chk(16'({flags, lk.irq}), 16'h0003);
        frame(1'b0, CMD_WRITE, ADDR_KEY, UNLOCK_KEYS[0]);
        frame(1'b0, CMD_WRITE, ADDR_WD_ACT, 8'h00);
        frame(1'b0, CMD_READ, ADDR_KEY, 8'h00);
        chk(16'({flags, rd[4:1], sirq}), 16'h0221);
        bang(8, 20);
        chk(16'(flags2), 16'h0004);
        lk2.sdi <= 1'b0;
        bang(8, 20);
        chk(16'({flags2, oe}), 16'h0008);
        bang(0, 1100);
        chk(16'({flags2[FLG_DUR], oe}), 16'h0003);
        report_and_stop();
    end
endmodule : spi_slave_protected_regs_tb
